// ===== shared/sfps_pkg.sv
// Constants, register map and carrier types of the supply fault sequencer.
// Assumes a single 40 MHz clock and comparator flags synchronous to it.
package sfps_pkg;
    // Clock and time base
    localparam int unsigned CLK_KHZ        = 40000;
    localparam int unsigned OVLD_DELAY_MS  = 64;
    localparam int unsigned OVLD_DELAY_CYC = OVLD_DELAY_MS * CLK_KHZ;
    localparam int unsigned OVLD_CNT_W     = 22;
    // Number of lockout turn-off events that release the overload latch
    localparam int unsigned OVLD_RELEASE_EVENTS = 2;

    // Register bus
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] MASK_OFS   = 4'h8;
    localparam logic [3:0] STATE_OFS  = 4'hc;

    // Control field and reset value
    localparam int unsigned CTRL_SWITCH_EN_BIT = 0;
    localparam logic        CTRL_RESET         = 1'b1;

    // Event bits, shared by status and mask
    localparam int unsigned EV_W           = 5;
    localparam int unsigned EV_OVLD_TRIP    = 0;
    localparam int unsigned EV_OVV_TRIP     = 1;
    localparam int unsigned EV_THERM_TRIP   = 2;
    localparam int unsigned EV_LOCKOUT_OFF  = 3;
    localparam int unsigned EV_OVLD_RELEASE = 4;
    localparam logic [4:0]  STATUS_RESET   = 5'h00;
    localparam logic [4:0]  MASK_RESET     = 5'h00;

    // State register bit positions
    localparam int unsigned ST_OVLD_LATCH  = 0;
    localparam int unsigned ST_OVV_LATCH   = 1;
    localparam int unsigned ST_THERM_LATCH = 2;
    localparam int unsigned ST_LOCKOUT_REL = 3;
    localparam int unsigned ST_GATE        = 4;
    localparam int unsigned ST_OVLD_EVCNT  = 5;
    localparam int unsigned ST_W           = 7;

    // Comparator flags from the analog front end
    typedef struct packed {
        logic overload_above;   // Feedback above overload level
        logic overvoltage;      // Supply above overvoltage level
        logic thermal_low;      // Sensor pin below trip level
        logic thermal_high;     // Sensor pin above restart level
        logic lockout_on;       // Supply reached turn-on level
        logic lockout_off;      // Supply fell to turn-off level
        logic power_down_clear; // Supply below power-down level
    } sfps_flags_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } sfps_bus_req_t;
endpackage

// ===== rtl/sfps_sequencer.sv
// Fault sequencer of an offline switching-supply controller: overload,
// supply overvoltage, thermal latch and undervoltage lockout gating.
// Assumes comparator flags are synchronous to clk_i and glitch free.
// Notes on behaviour
// - Feedback above the overload level for longer than 64 ms stops the gate.
// - Overload excursions of 64 ms or less never trip protection.
// - An overload trip latches the gate off and starts counting lockout offs.
// - The second counted lockout turn-off releases the overload latch.
// - A supply overvoltage flag removes the gate at once.
// - The overvoltage fault is latched and holds the gate off.
// - The overvoltage latch clears only under the power-down indication.
// - The sensor pin below its trip level turns the gate off and latches.
// - The thermal latch clears only under power-down with no thermal fault.
// - Thermal restart needs the pin above its restart level and power-down.
// - Lockout releases at the turn-on level and signals off at turn-off.
`timescale 1ns/1ps
`default_nettype none
module sfps_sequencer #(
    parameter int unsigned OVLD_DELAY_CYCLES = sfps_pkg::OVLD_DELAY_CYC
) (
    input  wire logic                        clk_i,
    input  wire logic                        reset_i,
    input  wire sfps_pkg::sfps_flags_t       flags_i,
    input  wire sfps_pkg::sfps_bus_req_t     bus_i,
    output logic [sfps_pkg::DATA_W-1:0]      rdata_o,
    output logic                             irq_o,
    output logic                             gate_enable_o
);
    if (OVLD_DELAY_CYCLES < 1 ||
        OVLD_DELAY_CYCLES >= (1 << sfps_pkg::OVLD_CNT_W)) begin : g_bad
        $error("overload delay out of counter range");
    end

    localparam logic [sfps_pkg::OVLD_CNT_W-1:0] DELAY =
        sfps_pkg::OVLD_CNT_W'(OVLD_DELAY_CYCLES);
    localparam logic [1:0] REL_LAST =
        2'(sfps_pkg::OVLD_RELEASE_EVENTS - 1);

    // State
    logic [sfps_pkg::OVLD_CNT_W-1:0] ovld_cnt;
    logic                           ovld_latch;
    logic [1:0]                     ovld_evcnt;
    logic                           ovv_latch;
    logic                           therm_latch;
    logic                           lockout_released;
    logic                           switch_en;
    logic [sfps_pkg::EV_W-1:0]      status;
    logic [sfps_pkg::EV_W-1:0]      mask;

    // Bus decode
    wire wr_ctrl   = bus_i.wr && bus_i.addr == sfps_pkg::CTRL_OFS;
    wire wr_status = bus_i.wr && bus_i.addr == sfps_pkg::STATUS_OFS;
    wire wr_mask   = bus_i.wr && bus_i.addr == sfps_pkg::MASK_OFS;

    // Lockout turn-off event
    wire lockout_off_ev = lockout_released && flags_i.lockout_off;

    // Overload qualification
    wire ovld_at_delay = ovld_cnt == DELAY;
    wire ovld_trip     = flags_i.overload_above && ovld_at_delay
                         && !ovld_latch;
    wire ovld_release  = ovld_latch && lockout_off_ev
                         && ovld_evcnt == REL_LAST;

    // Latch set and clear terms
    wire ovv_trip    = flags_i.overvoltage && !ovv_latch;
    wire ovv_clear   = flags_i.power_down_clear;
    wire therm_trip  = flags_i.thermal_low && !therm_latch;
    wire therm_clear = flags_i.power_down_clear && !flags_i.thermal_low
                       && flags_i.thermal_high;

    wire [sfps_pkg::EV_W-1:0] events = {
        ovld_release, lockout_off_ev, therm_trip, ovv_trip, ovld_trip
    };
    wire [sfps_pkg::EV_W-1:0] status_clr =
        wr_status ? bus_i.wdata[sfps_pkg::EV_W-1:0] : '0;

    wire [sfps_pkg::ST_W-1:0] state_word = {
        ovld_evcnt, gate_enable_o, lockout_released,
        therm_latch, ovv_latch, ovld_latch
    };

    wire [sfps_pkg::DATA_W-1:0] rd_mux =
        bus_i.addr == sfps_pkg::CTRL_OFS   ? {31'h0, switch_en} :
        bus_i.addr == sfps_pkg::STATUS_OFS ? {27'h0, status} :
        bus_i.addr == sfps_pkg::MASK_OFS   ? {27'h0, mask} :
        bus_i.addr == sfps_pkg::STATE_OFS  ? {25'h0, state_word} :
        32'h0;

    // Overload delay counter, restarts whenever the excursion ends
    always_ff @(posedge clk_i) begin
        if (reset_i || !flags_i.overload_above || ovld_latch) begin
            ovld_cnt <= '0;
        end else if (!ovld_at_delay) begin
            ovld_cnt <= ovld_cnt + 1'b1;
        end
    end

    // Overload latch with divide-by-two release
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ovld_latch <= 1'b0;
            ovld_evcnt <= 2'h0;
        end else if (ovld_trip) begin
            ovld_latch <= 1'b1;
            ovld_evcnt <= 2'h0;
        end else if (ovld_release) begin
            ovld_latch <= 1'b0;
            ovld_evcnt <= 2'h0;
        end else if (ovld_latch && lockout_off_ev) begin
            ovld_evcnt <= ovld_evcnt + 2'h1;
        end
    end

    // Overvoltage and thermal latches, a set wins over a clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ovv_latch   <= 1'b0;
            therm_latch <= 1'b0;
        end else begin
            ovv_latch   <= flags_i.overvoltage
                           || (ovv_latch && !ovv_clear);
            therm_latch <= flags_i.thermal_low
                           || (therm_latch && !therm_clear);
        end
    end

    // Undervoltage lockout hysteresis, off level has priority
    always_ff @(posedge clk_i) begin
        if (reset_i || flags_i.lockout_off) begin
            lockout_released <= 1'b0;
        end else if (flags_i.lockout_on) begin
            lockout_released <= 1'b1;
        end
    end

    // Registers, a new event wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            switch_en <= sfps_pkg::CTRL_RESET;
            status    <= sfps_pkg::STATUS_RESET;
            mask      <= sfps_pkg::MASK_RESET;
            rdata_o   <= '0;
        end else begin
            if (wr_ctrl) begin
                switch_en <= bus_i.wdata[sfps_pkg::CTRL_SWITCH_EN_BIT];
            end
            if (wr_mask) begin
                mask <= bus_i.wdata[sfps_pkg::EV_W-1:0];
            end
            status  <= (status & ~status_clr) | events;
            rdata_o <= bus_i.rd ? rd_mux : '0;
        end
    end

    assign irq_o = |(status & mask);

    // Overvoltage and thermal flags gate directly so shutdown is immediate
    assign gate_enable_o = !ovld_latch && !ovv_latch && !therm_latch
                           && !flags_i.overvoltage && !flags_i.thermal_low
                           && lockout_released && switch_en;

    // Checks
    property p_ovld_needs_delay;
        @(posedge clk_i) disable iff (reset_i)
        $rose(ovld_latch) |-> $past(ovld_cnt) == DELAY
                              && $past(flags_i.overload_above);
    endproperty
    a_ovld_needs_delay: assert property (p_ovld_needs_delay)
        else $error("overload latched before the full delay");

    property p_ovld_trip_sets;
        @(posedge clk_i) disable iff (reset_i)
        ovld_trip |=> ovld_latch && !gate_enable_o;
    endproperty
    a_ovld_trip_sets: assert property (p_ovld_trip_sets)
        else $error("overload trip did not stop the gate");

    property p_ovld_holds;
        @(posedge clk_i) disable iff (reset_i)
        ovld_latch && !lockout_off_ev |=> ovld_latch;
    endproperty
    a_ovld_holds: assert property (p_ovld_holds)
        else $error("overload latch dropped without a lockout off");

    sequence s_first_off;
        ovld_latch && lockout_off_ev && ovld_evcnt == 2'h0;
    endsequence
    sequence s_counted_one;
        ovld_latch && ovld_evcnt == 2'h1;
    endsequence
    property p_ovld_first_off;
        @(posedge clk_i) disable iff (reset_i)
        s_first_off |=> s_counted_one;
    endproperty
    a_ovld_first_off: assert property (p_ovld_first_off)
        else $error("first lockout off not counted");

    property p_ovld_release;
        @(posedge clk_i) disable iff (reset_i)
        s_counted_one ##0 lockout_off_ev |=> !ovld_latch
                                             && ovld_evcnt == 2'h0;
    endproperty
    a_ovld_release: assert property (p_ovld_release)
        else $error("second lockout off did not release overload");

    property p_ovv_immediate;
        @(posedge clk_i) disable iff (reset_i)
        flags_i.overvoltage |-> !gate_enable_o ##1 ovv_latch;
    endproperty
    a_ovv_immediate: assert property (p_ovv_immediate)
        else $error("overvoltage did not stop the gate at once");

    property p_ovv_sticky;
        @(posedge clk_i) disable iff (reset_i)
        ovv_latch && !flags_i.power_down_clear |=> ovv_latch;
    endproperty
    a_ovv_sticky: assert property (p_ovv_sticky)
        else $error("overvoltage latch cleared without power-down");

    property p_ovv_clear;
        @(posedge clk_i) disable iff (reset_i)
        ovv_latch && flags_i.power_down_clear && !flags_i.overvoltage
        |=> !ovv_latch;
    endproperty
    a_ovv_clear: assert property (p_ovv_clear)
        else $error("overvoltage latch not cleared at power-down");

    property p_therm_trip;
        @(posedge clk_i) disable iff (reset_i)
        flags_i.thermal_low |-> !gate_enable_o ##1 therm_latch;
    endproperty
    a_therm_trip: assert property (p_therm_trip)
        else $error("thermal fault did not latch the gate off");

    property p_therm_hold;
        @(posedge clk_i) disable iff (reset_i)
        therm_latch && !(flags_i.power_down_clear && flags_i.thermal_high)
        |=> therm_latch;
    endproperty
    a_therm_hold: assert property (p_therm_hold)
        else $error("thermal latch cleared without both conditions");

    property p_lockout_off;
        @(posedge clk_i) disable iff (reset_i)
        flags_i.lockout_off |=> !lockout_released && !gate_enable_o;
    endproperty
    a_lockout_off: assert property (p_lockout_off)
        else $error("lockout off level did not block the gate");

    property p_gate_and;
        @(posedge clk_i) disable iff (reset_i)
        gate_enable_o |-> lockout_released && !ovld_latch && !ovv_latch
                          && !therm_latch;
    endproperty
    a_gate_and: assert property (p_gate_and)
        else $error("gate enabled with a latch set or lockout held");

    property p_status_set_wins;
        @(posedge clk_i) disable iff (reset_i)
        ovv_trip && wr_status |=> status[sfps_pkg::EV_OVV_TRIP];
    endproperty
    a_status_set_wins: assert property (p_status_set_wins)
        else $error("status event lost against a clear");
endmodule
`default_nettype wire

// ===== sim/sfps_front_model.sv
// Behavioural comparators of the supply, feedback and sensor pins.
// Assumes levels in millivolts, set by the bench just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module sfps_front_model #(
    // Overvoltage level is not given; plain default
    parameter logic [15:0] OVV_MV = 16'h6978
) (
    input  wire logic                  clk_i,
    input  wire logic [15:0]           vcc_mv_i,
    input  wire logic [15:0]           comp_mv_i,
    input  wire logic [15:0]           sense_mv_i,
    output var  sfps_pkg::sfps_flags_t flags_o
);
    always_ff @(posedge clk_i) begin
        flags_o.overload_above   <= comp_mv_i > 16'h1388;
        flags_o.overvoltage      <= vcc_mv_i > OVV_MV;
        flags_o.thermal_low      <= sense_mv_i < 16'h03b6;
        flags_o.thermal_high     <= sense_mv_i > 16'h041a;
        flags_o.lockout_on       <= vcc_mv_i >= 16'h3e80;
        flags_o.lockout_off      <= vcc_mv_i <= 16'h2710;
        flags_o.power_down_clear <= vcc_mv_i < 16'h1f40;
    end
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench of the supply fault sequencer.
// Assumes the front model turns supply levels into comparator flags.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int unsigned DLY   = 20;
    localparam logic [15:0] V_OFF = 16'h1b58;
    localparam logic [15:0] V_LOW = 16'h2328;
    localparam logic [15:0] V_RUN = 16'h4268;
    localparam logic [15:0] V_OVV = 16'h7530;
    logic                    clk_i   = 1'b0;
    logic                    reset_i = 1'b1;
    logic [15:0]             vcc     = 16'h0000;
    logic [15:0]             comp    = 16'h07d0;
    logic [15:0]             sense   = 16'h044c;
    sfps_pkg::sfps_flags_t   flags;
    sfps_pkg::sfps_bus_req_t bus     = '0;
    logic [31:0]             rdata;
    logic                    irq;
    logic                    gate;
    int                      miscompares = 0;
    int                      checks_done = 0;

    always #12.5 clk_i = ~clk_i;

    sfps_front_model u_front (.clk_i(clk_i), .vcc_mv_i(vcc), .comp_mv_i(comp),
        .sense_mv_i(sense), .flags_o(flags));
    sfps_sequencer #(.OVLD_DELAY_CYCLES(DLY)) u_dut (.clk_i(clk_i),
        .reset_i(reset_i), .flags_i(flags), .bus_i(bus), .rdata_o(rdata),
        .irq_o(irq), .gate_enable_o(gate));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Samples gate (sel 0) or irq (sel 1) mid-cycle
    task automatic pin(input logic sel, input logic exp);
        @(negedge clk_i);
        chk({31'h0, sel ? irq : gate}, {31'h0, exp});
        @(posedge clk_i);
    endtask
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_i);
        bus.wr <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic bus_rd(input logic [3:0] a, input logic [31:0] exp);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_i);
        bus.rd <= 1'b0;
        @(negedge clk_i);
        chk(rdata, exp);
        @(posedge clk_i);
    endtask
    task automatic cycle_supply(input logic [15:0] low);
        vcc <= low;
        step(3);
        vcc <= V_RUN;
        step(3);
    endtask

    task automatic t_reset;
        bus_rd(sfps_pkg::CTRL_OFS, 32'h1);
        bus_rd(sfps_pkg::STATUS_OFS, 32'h0);
        bus_rd(sfps_pkg::MASK_OFS, 32'h0);
        pin(1'b0, 1'b0);
        vcc <= V_RUN;
        step(3);
        pin(1'b0, 1'b1);
        bus_rd(sfps_pkg::STATE_OFS, 32'h18);
        $display("test reset done");
    endtask
    task automatic t_overload;
        bus_wr(sfps_pkg::STATUS_OFS, 32'h1f);
        comp <= 16'h1770;
        step(DLY);
        comp <= 16'h07d0;
        step(3);
        pin(1'b0, 1'b1);
        comp <= 16'h1770;
        step(DLY + 1);
        comp <= 16'h07d0;
        step(2);
        pin(1'b0, 1'b0);
        cycle_supply(V_LOW);
        pin(1'b0, 1'b0);
        cycle_supply(V_LOW);
        pin(1'b0, 1'b1);
        bus_rd(sfps_pkg::STATUS_OFS, 32'h19);
        $display("test overload done");
    endtask
    task automatic t_ovv;
        vcc <= V_OVV;
        step(1);
        pin(1'b0, 1'b0);
        vcc <= V_RUN;
        step(3);
        pin(1'b0, 1'b0);
        cycle_supply(V_LOW);
        pin(1'b0, 1'b0);
        cycle_supply(V_OFF);
        pin(1'b0, 1'b1);
        $display("test overvoltage done");
    endtask
    task automatic t_thermal;
        sense <= 16'h0384;
        step(1);
        pin(1'b0, 1'b0);
        sense <= 16'h044c;
        step(3);
        pin(1'b0, 1'b0);
        sense <= 16'h03e8;
        cycle_supply(V_OFF);
        pin(1'b0, 1'b0);
        sense <= 16'h044c;
        cycle_supply(V_OFF);
        pin(1'b0, 1'b1);
        $display("test thermal done");
    endtask
    task automatic t_regs;
        bus_wr(sfps_pkg::MASK_OFS, 32'h02);
        bus_wr(sfps_pkg::STATUS_OFS, 32'h1f);
        pin(1'b1, 1'b0);
        // Clear lands on the same edge as the trip event: set must win
        vcc <= V_OVV;
        step(1);
        bus_wr(sfps_pkg::STATUS_OFS, 32'h02);
        pin(1'b1, 1'b1);
        bus_wr(sfps_pkg::STATUS_OFS, 32'h02);
        pin(1'b1, 1'b0);
        bus_wr(sfps_pkg::STATE_OFS, 32'h0);
        bus_rd(sfps_pkg::STATE_OFS, 32'h0a);
        bus_rd(4'h2, 32'h0);
        cycle_supply(V_OFF);
        bus_wr(sfps_pkg::CTRL_OFS, 32'h0);
        pin(1'b0, 1'b0);
        bus_wr(sfps_pkg::CTRL_OFS, 32'h1);
        pin(1'b0, 1'b1);
        $display("test registers done");
    endtask

    task automatic end_sim;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        step(12);
        reset_i <= 1'b0;
        step(1);
        t_reset;
        t_overload;
        t_ovv;
        t_thermal;
        t_regs;
        end_sim;
    end
    initial begin
        #75000;
        miscompares++;
        end_sim;
    end
endmodule
`default_nettype wire
